/* hdl/rpac_map.svh */
// register offsets, field positions, reset values and timing counts for the ref pll control bank
`ifndef RPAC_MAP_SVH
`define RPAC_MAP_SVH
`define RPAC_OFS_BASIC 8'h25
`define RPAC_OFS_HOLD 8'h26
`define RPAC_OFS_FAST 8'h27
`define RPAC_OFS_NORM 8'h28
`define RPAC_OFS_RDIV_HI 8'h29
`define RPAC_OFS_RDIV_LO 8'h2a
`define RPAC_OFS_NDIV_HI 8'h2b
`define RPAC_OFS_NDIV_LO 8'h2c
`define RPAC_OFS_STEP 8'h2d
`define RPAC_BIT_HALVE 4
`define RPAC_BIT_BUFTYPE 2
`define RPAC_BIT_FASTEN 0
`define RPAC_RST_BASIC 8'h01
`define RPAC_RST_HOLD 8'h00
`define RPAC_RST_FAST 8'h1f
`define RPAC_RST_NORM 8'h08
`define RPAC_RST_RDIV_HI 8'h00
`define RPAC_RST_RDIV_LO 8'h01
`define RPAC_RST_NDIV_HI 8'h06
`define RPAC_RST_NDIV_LO 8'hb4
`define RPAC_RST_STEP 8'h08
`define RPAC_MASK_BASIC 8'h15
`define RPAC_MASK_HOLD 8'h0f
`define RPAC_MASK_5B 8'h1f
`define RPAC_MASK_RDIV_HI 8'h03
`define RPAC_MASK_NDIV_HI 8'h7f
`define RPAC_HOLD_UNIT_MS 500
`define RPAC_CLOCK_MHZ 250
`define RPAC_TICK_CYCLES (`RPAC_HOLD_UNIT_MS * 1000 * `RPAC_CLOCK_MHZ)
`endif

/* hdl/rpac_pkg.sv */
// types shared by the ref pll control bank
package rpac_pkg;
  typedef enum logic [1:0] {
    RPAC_ACQUIRE,
    RPAC_HOLD,
    RPAC_NORMAL
  } rpac_state_t;
endpackage : rpac_pkg

/* hdl/rpac_hold_timer.sv */
// half-second tick generator and hold counter for the fast-acquire timer
`timescale 1ns/10ps
`include "rpac_map.svh"
module rpac_hold_timer #(
  parameter int TICK_CYCLES = `RPAC_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic run,
  input wire logic [3:0] target,
  output logic done
);
  logic [31:0] tick_q, tick_d;
  logic [3:0] units_q, units_d;

  // counter restarts from zero whenever run drops, so lock loss restarts the hold
  always_comb begin
    tick_d = tick_q;
    units_d = units_q;
    if (!run) begin
      tick_d = '0;
      units_d = '0;
    end else if (units_q != target) begin
      if (tick_q == 32'(TICK_CYCLES - 1)) begin
        tick_d = '0;
        units_d = units_q + 4'h1;
      end else begin
        tick_d = tick_q + 32'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      tick_q <= '0;
      units_q <= '0;
    end else begin
      tick_q <= tick_d;
      units_q <= units_d;
    end
  end

  assign done = run && (units_q == target);
endmodule : rpac_hold_timer

/* hdl/rpac_ctrl.sv */
// register bank and fast-acquire control of the reference pll
//
// How it works
// - ref_out_halve clear gives divide by one (27 MHz), set gives divide by two (13.5 MHz).
// - bit 2 of the basic options register drives the input buffer type, 1 differential.
// - with fast acquire enabled (reset 1) the fast pump current is used while acquiring.
// - lock must stand for hold count times 0.5 s before falling back to normal current.
// - fast acquisition uses the 5-bit fast current field, reset 11111, 34.375 uA per step.
// - otherwise the 5-bit normal current field, reset 01000, is used with the same scale.
// - the reference divider is hi[1:0] over the low byte, the low byte resetting to 0x01.
// - the reference divider loads from the format and is read-only while auto detect is on.
// - the feedback divider is hi[6:0] over the low byte, the low byte resetting to 0xb4.
// - with auto detect off the host may write the format-controlled divider registers.
`timescale 1ns/10ps
`include "rpac_map.svh"
module rpac_ctrl import rpac_pkg::*; #(
  parameter int TICK_CYCLES = `RPAC_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic auto_format_detect_enable,
  input wire logic fmt_load,
  input wire logic [9:0] fmt_ref_div,
  input wire logic [14:0] fmt_fb_div,
  input wire logic ref_locked,
  output logic ref_out_halve,
  output logic ref_input_buffer_type,
  output logic [4:0] pump_current,
  output logic fast_active,
  output logic [9:0] ref_divider,
  output logic [14:0] feedback_divider,
  output logic [4:0] lock_detect_step
);
  logic [7:0] basic_q, basic_d, hold_q, hold_d, fast_q, fast_d, norm_q, norm_d;
  logic [7:0] rhi_q, rhi_d, rlo_q, rlo_d, nhi_q, nhi_d, nlo_q, nlo_d, step_q, step_d;
  logic [7:0] rdata_d;
  logic [1:0] lock_s_q;
  logic locked;
  logic timer_done;
  rpac_state_t st_q, st_d;
  logic [4:0] pump_d;

  // write strobe for one offset, used by every register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  // host writes; divider words are refused while auto detect owns them
  always_comb begin
    basic_d = basic_q;
    hold_d = hold_q;
    fast_d = fast_q;
    norm_d = norm_q;
    rhi_d = rhi_q;
    rlo_d = rlo_q;
    nhi_d = nhi_q;
    nlo_d = nlo_q;
    step_d = step_q;
    if (reg_wr) begin
      if (hit(reg_addr, `RPAC_OFS_BASIC)) basic_d = reg_wdata & `RPAC_MASK_BASIC;
      if (hit(reg_addr, `RPAC_OFS_HOLD)) hold_d = reg_wdata & `RPAC_MASK_HOLD;
      if (hit(reg_addr, `RPAC_OFS_FAST)) fast_d = reg_wdata & `RPAC_MASK_5B;
      if (hit(reg_addr, `RPAC_OFS_NORM)) norm_d = reg_wdata & `RPAC_MASK_5B;
      if (hit(reg_addr, `RPAC_OFS_STEP)) step_d = reg_wdata & `RPAC_MASK_5B;
      if (!auto_format_detect_enable) begin
        if (hit(reg_addr, `RPAC_OFS_RDIV_HI)) rhi_d = reg_wdata & `RPAC_MASK_RDIV_HI;
        if (hit(reg_addr, `RPAC_OFS_RDIV_LO)) rlo_d = reg_wdata;
        if (hit(reg_addr, `RPAC_OFS_NDIV_HI)) nhi_d = reg_wdata & `RPAC_MASK_NDIV_HI;
        if (hit(reg_addr, `RPAC_OFS_NDIV_LO)) nlo_d = reg_wdata;
      end
    end
    // format loads come from the detector only while it is enabled
    if (fmt_load && auto_format_detect_enable) begin
      rhi_d = {6'h00, fmt_ref_div[9:8]};
      rlo_d = fmt_ref_div[7:0];
      nhi_d = {1'b0, fmt_fb_div[14:8]};
      nlo_d = fmt_fb_div[7:0];
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      `RPAC_OFS_BASIC: rdata_d = basic_q;
      `RPAC_OFS_HOLD: rdata_d = hold_q;
      `RPAC_OFS_FAST: rdata_d = fast_q;
      `RPAC_OFS_NORM: rdata_d = norm_q;
      `RPAC_OFS_RDIV_HI: rdata_d = rhi_q;
      `RPAC_OFS_RDIV_LO: rdata_d = rlo_q;
      `RPAC_OFS_NDIV_HI: rdata_d = nhi_q;
      `RPAC_OFS_NDIV_LO: rdata_d = nlo_q;
      `RPAC_OFS_STEP: rdata_d = step_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      basic_q <= `RPAC_RST_BASIC;
      hold_q <= `RPAC_RST_HOLD;
      fast_q <= `RPAC_RST_FAST;
      norm_q <= `RPAC_RST_NORM;
      rhi_q <= `RPAC_RST_RDIV_HI;
      rlo_q <= `RPAC_RST_RDIV_LO;
      nhi_q <= `RPAC_RST_NDIV_HI;
      nlo_q <= `RPAC_RST_NDIV_LO;
      step_q <= `RPAC_RST_STEP;
      reg_rdata <= 8'h00;
    end else begin
      basic_q <= basic_d;
      hold_q <= hold_d;
      fast_q <= fast_d;
      norm_q <= norm_d;
      rhi_q <= rhi_d;
      rlo_q <= rlo_d;
      nhi_q <= nhi_d;
      nlo_q <= nlo_d;
      step_q <= step_d;
      reg_rdata <= reg_rd ? rdata_d : 8'h00;
    end
  end

  // lock comes from the analog loop, so it is synchronised first
  always_ff @(posedge clock) begin
    if (!rstn) lock_s_q <= 2'b00;
    else lock_s_q <= {lock_s_q[0], ref_locked};
  end
  assign locked = lock_s_q[1];

  // hold timer runs only while lock stands in the hold state
  rpac_hold_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clock(clock),
    .rstn(rstn),
    .run(st_q == RPAC_HOLD && locked),
    .target(hold_q[3:0]),
    .done(timer_done)
  );

  // acquire, hold after lock, then normal; lock loss goes back to acquire
  always_comb begin
    st_d = st_q;
    case (st_q)
      RPAC_ACQUIRE: if (locked) st_d = RPAC_HOLD;
      RPAC_HOLD: begin
        if (!locked) st_d = RPAC_ACQUIRE;
        else if (timer_done) st_d = RPAC_NORMAL;
      end
      RPAC_NORMAL: if (!locked) st_d = RPAC_ACQUIRE;
      default: st_d = RPAC_ACQUIRE;
    endcase
    // disabling fast acquire uses normal current in every state
    pump_d = (basic_q[`RPAC_BIT_FASTEN] && st_d != RPAC_NORMAL) ? fast_q[4:0]
                                                                 : norm_q[4:0];
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_q <= RPAC_ACQUIRE;
      pump_current <= 5'(`RPAC_RST_FAST);
      fast_active <= 1'b1;
      ref_out_halve <= 1'b0;
      ref_input_buffer_type <= 1'b0;
      ref_divider <= 10'h001;
      feedback_divider <= 15'h06b4;
      lock_detect_step <= 5'h08;
    end else begin
      st_q <= st_d;
      pump_current <= pump_d;
      fast_active <= basic_q[`RPAC_BIT_FASTEN] && st_d != RPAC_NORMAL;
      ref_out_halve <= basic_q[`RPAC_BIT_HALVE];
      ref_input_buffer_type <= basic_q[`RPAC_BIT_BUFTYPE];
      ref_divider <= {rhi_q[1:0], rlo_q};
      feedback_divider <= {nhi_q[6:0], nlo_q};
      lock_detect_step <= step_q[4:0];
    end
  end

  property p_refuse_rdiv;
    @(posedge clock) disable iff (!rstn)
      (reg_wr && auto_format_detect_enable && !fmt_load) |=> rlo_q == $past(rlo_q);
  endproperty
  a_refuse_rdiv: assert property (p_refuse_rdiv) else $error("ref div written while auto");
  property p_refuse_ndiv;
    @(posedge clock) disable iff (!rstn)
      (reg_wr && auto_format_detect_enable && !fmt_load) |=> nlo_q == $past(nlo_q);
  endproperty
  a_refuse_ndiv: assert property (p_refuse_ndiv) else $error("fb div written while auto");
  property p_manual_wr;
    @(posedge clock) disable iff (!rstn)
      (reg_wr && !auto_format_detect_enable && reg_addr == `RPAC_OFS_RDIV_LO)
        |=> rlo_q == $past(reg_wdata);
  endproperty
  a_manual_wr: assert property (p_manual_wr) else $error("manual divider write lost");
  property p_reserved_bits;
    @(posedge clock) disable iff (!rstn) (basic_q & ~`RPAC_MASK_BASIC) == 8'h00;
  endproperty
  a_reserved_bits: assert property (p_reserved_bits) else $error("reserved bits set");
  property p_halve;
    @(posedge clock) disable iff (!rstn) ##1 ref_out_halve == $past(basic_q[4]);
  endproperty
  a_halve: assert property (p_halve) else $error("halve output wrong");
  property p_buf;
    @(posedge clock) disable iff (!rstn) ##1 ref_input_buffer_type == $past(basic_q[2]);
  endproperty
  a_buf: assert property (p_buf) else $error("buffer type wrong");
  property p_fast_cur;
    @(posedge clock) disable iff (!rstn) fast_active |-> pump_current == $past(fast_q[4:0]);
  endproperty
  a_fast_cur: assert property (p_fast_cur) else $error("fast current not used");
  property p_norm_cur;
    @(posedge clock) disable iff (!rstn) !fast_active |-> pump_current == $past(norm_q[4:0]);
  endproperty
  a_norm_cur: assert property (p_norm_cur) else $error("normal current not used");
  property p_loss;
    @(posedge clock) disable iff (!rstn)
      (st_q == RPAC_HOLD && !locked) |=> st_q == RPAC_ACQUIRE;
  endproperty
  a_loss: assert property (p_loss) else $error("hold not restarted");
  property p_fasten;
    @(posedge clock) disable iff (!rstn)
      (basic_q[0] && st_q == RPAC_ACQUIRE && !locked) |=> fast_active;
  endproperty
  a_fasten: assert property (p_fasten) else $error("fast acquire not applied");
  property p_zero_hold;
    @(posedge clock) disable iff (!rstn)
      (st_q == RPAC_HOLD && locked && hold_q == 8'h00) |=> st_q == RPAC_NORMAL;
  endproperty
  a_zero_hold: assert property (p_zero_hold) else $error("zero hold not immediate");
endmodule : rpac_ctrl

/* testbench/rpac_host.sv */
// host-side register access model for the ref pll control bank
`timescale 1ns/10ps
`include "rpac_map.svh"
module rpac_host (
  input wire logic clock,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one write; address and data flip once released so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == `RPAC_OFS_HOLD && d[3:0] > 4'ha) d[3:0] = 4'ha;
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  // one read; data is registered so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
endmodule : rpac_host

/* testbench/ref_pll_advanced_control_test.sv */
// self-checking bench for the ref pll control bank
`timescale 1ns/10ps
`include "rpac_map.svh"
module ref_pll_advanced_control_test;
  localparam int TICK = 10;
  logic clock = 1'b0, rstn = 1'b0, afd = 1'b0, fmt_load = 1'b0, ref_locked = 1'b0;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [9:0] fmt_ref_div = 10'h000, ref_divider;
  logic [14:0] fmt_fb_div = 15'h0000, feedback_divider;
  logic ref_out_halve, ref_input_buffer_type, fast_active;
  logic [4:0] pump_current, lock_detect_step;
  logic [7:0] sh [9] = '{8'h01, 8'h00, 8'h1f, 8'h08, 8'h00, 8'h01, 8'h06, 8'hb4, 8'h08};
  logic [31:0] seed = 32'h7c476da1;
  int failures = 0, cmp_count = 0, cycles = 0;
  rpac_ctrl #(.TICK_CYCLES(TICK)) u_dut (.clock(clock), .rstn(rstn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .auto_format_detect_enable(afd), .fmt_load(fmt_load), .fmt_ref_div(fmt_ref_div),
    .fmt_fb_div(fmt_fb_div), .ref_locked(ref_locked), .ref_out_halve(ref_out_halve),
    .ref_input_buffer_type(ref_input_buffer_type), .pump_current(pump_current),
    .fast_active(fast_active), .ref_divider(ref_divider), .feedback_divider(feedback_divider),
    .lock_detect_step(lock_detect_step));
  rpac_host u_host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  always #2 clock = ~clock;
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      final_report();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // readable value of a register: reserved bits zero, hold count clipped by the host
  function automatic logic [7:0] exp_reg(input int i, input logic [7:0] d);
    logic [7:0] m [9] = '{8'h15, 8'h0f, 8'h1f, 8'h1f, 8'h03, 8'hff, 8'h7f, 8'hff, 8'h1f};
    if (i == 1 && d[3:0] > 4'ha) d[3:0] = 4'ha;
    return d & m[i];
  endfunction : exp_reg
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic read_all();
    for (int i = 0; i < 9; i++) begin
      u_host.rd(8'h25 + 8'(i), rv);
      chk({8'h00, rv}, {8'h00, sh[i]});
    end
    u_host.rd(8'h2e, rv);
    chk({8'h00, rv}, 16'h0000);
    chk({6'h00, ref_divider}, {6'h00, sh[4][1:0], sh[5]});
    chk({1'b0, feedback_divider}, {1'b0, sh[6][6:0], sh[7]});
    chk({11'h000, lock_detect_step}, {11'h000, sh[8][4:0]});
    chk({14'h0000, ref_out_halve, ref_input_buffer_type}, {14'h0000, sh[0][4], sh[0][2]});
    chk({11'h000, pump_current}, {11'h000, sh[0][0] ? sh[2][4:0] : sh[3][4:0]});
  endtask : read_all
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  initial begin
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    read_all();
    $display("test reset values done");
    // random host writes with auto detection off, including reserved bits
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 9; i++) begin
        rv = 8'(rnd());
        u_host.wr(8'h25 + 8'(i), rv);
        sh[i] = exp_reg(i, rv);
      end
      u_host.wr(8'h2e, 8'(rnd()));
      read_all();
    end
    $display("test random writes done");
    // auto detection: host writes ignored, format loads take effect
    @(negedge clock);
    afd = 1'b1;
    for (int i = 4; i < 8; i++) u_host.wr(8'h25 + 8'(i), 8'(rnd()));
    read_all();
    @(negedge clock);
    fmt_ref_div = 10'(rnd());
    fmt_fb_div = 15'(rnd());
    fmt_load = 1'b1;
    @(negedge clock);
    fmt_load = 1'b0;
    {sh[4], sh[5]} = {6'h00, fmt_ref_div};
    {sh[6], sh[7]} = {1'b0, fmt_fb_div};
    read_all();
    afd = 1'b0;
    // a load pulse while auto detect is off must leave the divider words alone
    @(negedge clock);
    fmt_ref_div = ~fmt_ref_div;
    fmt_fb_div = ~fmt_fb_div;
    fmt_load = 1'b1;
    @(negedge clock);
    fmt_load = 1'b0;
    read_all();
    $display("test auto format done");
    // lock hold of two ticks, with a dropout that must restart the timer
    u_host.wr(8'h25, 8'h01);
    u_host.wr(8'h26, 8'h02);
    sh[0] = 8'h01;
    sh[1] = 8'h02;
    ref_locked = 1'b1;
    repeat (2 * TICK - 5) @(negedge clock);
    chk({15'h0000, fast_active}, 16'h0001);
    ref_locked = 1'b0;
    repeat (3) @(negedge clock);
    ref_locked = 1'b1;
    repeat (2 * TICK - 5) @(negedge clock);
    chk({15'h0000, fast_active}, 16'h0001);
    chk({11'h000, pump_current}, {11'h000, sh[2][4:0]});
    repeat (8) @(negedge clock);
    chk({15'h0000, fast_active}, 16'h0001);
    @(negedge clock);
    chk({15'h0000, fast_active}, 16'h0000);
    chk({11'h000, pump_current}, {11'h000, sh[3][4:0]});
    ref_locked = 1'b0;
    u_host.wr(8'h25, 8'h00);
    sh[0] = 8'h00;
    repeat (6) @(negedge clock);
    read_all();
    // zero hold count: normal current one cycle after the hold state is entered
    u_host.wr(8'h25, 8'h01);
    u_host.wr(8'h26, 8'h00);
    sh[0] = 8'h01;
    sh[1] = 8'h00;
    ref_locked = 1'b1;
    repeat (3) @(negedge clock);
    chk({15'h0000, fast_active}, 16'h0001);
    @(negedge clock);
    chk({15'h0000, fast_active}, 16'h0000);
    chk({11'h000, pump_current}, {11'h000, sh[3][4:0]});
    $display("test lock hold done");
    final_report();
  end
endmodule : ref_pll_advanced_control_test
